// file: pkg/adc_ctrl_pkg.sv
// Register map, field layout and timing constants for the converter control
package adc_ctrl_pkg;
  // Printed offsets are not all multiples of four: they are word indices
  localparam logic [7:0] IDX_MODE_CH = 8'h0e;
  localparam logic [7:0] IDX_TIMING = 8'h0f;
  localparam logic [7:0] IDX_RES_LOW = 8'h20;
  localparam logic [7:0] IDX_RES_HIGH = 8'h21;
  // Own register for standby control
  localparam logic [7:0] IDX_STANDBY = 8'h30;
  localparam logic [9:0] ADDR_MODE_CH = {IDX_MODE_CH, 2'b00};
  localparam logic [9:0] ADDR_TIMING = {IDX_TIMING, 2'b00};
  localparam logic [9:0] ADDR_RES_LOW = {IDX_RES_LOW, 2'b00};
  localparam logic [9:0] ADDR_RES_HIGH = {IDX_RES_HIGH, 2'b00};
  localparam logic [9:0] ADDR_STANDBY = {IDX_STANDBY, 2'b00};
  // Field positions
  localparam int START_POS = 7;
  localparam int MODE_POS = 5;
  localparam int GATE_POS = 4;
  localparam int CH_POS = 0;
  localparam int KEEP_POS = 5;
  localparam int TIME_POS = 1;
  localparam int DONE_POS = 5;
  localparam int BUSY_POS = 4;
  // Reset values
  localparam logic [7:0] MODE_CH_RESET = 8'h10;
  localparam logic [7:0] TIMING_RESET = 8'h10;
  localparam logic [7:0] RES_HIGH_RESET = 8'h00;
  // Operating modes
  localparam logic [1:0] MODE_OFF = 2'b00;
  localparam logic [1:0] MODE_SINGLE = 2'b01;
  localparam logic [1:0] MODE_REPEAT = 2'b11;
  // Conversion times in hf_osc_clock cycles
  localparam logic [10:0] CONV_39 = 11'h027;
  localparam logic [10:0] CONV_78 = 11'h04e;
  localparam logic [10:0] CONV_156 = 11'h09c;
  localparam logic [10:0] CONV_312 = 11'h138;
  localparam logic [10:0] CONV_624 = 11'h270;
  localparam logic [10:0] CONV_1248 = 11'h4e0;
  localparam int NUM_CHANNELS = 8;
  localparam int RES_BITS = 10;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b11
  } seq_state_t;
endpackage

// file: logic/sar_sequencer.sv
// Successive approximation sequencer: timed bit-by-bit result resolution
`timescale 1ns/1ps
`default_nettype none
module sar_sequencer #(
  parameter int WIDTH = 10
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic start, // Begin a conversion
  input wire logic abort, // Drop conversion at once
  input wire logic [10:0] conv_cycles, // Total cycles of conversion
  input wire logic comp_in, // Comparator: input above DAC
  output logic [WIDTH-1:0] dac_code, // Ladder DAC setting
  output logic busy, // Conversion running
  output logic finish, // One-cycle completion pulse
  output logic [WIDTH-1:0] result // Final resolved value
);
  localparam logic [10:0] ONE = 11'h001;
  logic [10:0] cnt_reg;
  logic [WIDTH-1:0] trial_reg;
  logic [WIDTH-1:0] bit_reg;
  logic busy_reg;
  logic finish_reg;
  logic [WIDTH-1:0] result_reg;
  logic [10:0] step_len;
  logic [10:0] step_cnt_reg;
  logic step_tick;
  logic last_tick;
  logic [WIDTH-1:0] decided;

  // Bit step length spreads the conversion time over WIDTH steps
  assign step_len = conv_cycles / 11'(WIDTH);
  assign step_tick = busy_reg && (step_cnt_reg == step_len - ONE);
  assign last_tick = busy_reg && (cnt_reg == conv_cycles - ONE);
  assign decided = comp_in ? trial_reg : (trial_reg & ~bit_reg);
  assign dac_code = trial_reg;
  assign busy = busy_reg;
  assign finish = finish_reg;
  assign result = result_reg;

  // Counter, MSB-first trials and completion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= '0;
      step_cnt_reg <= '0;
      trial_reg <= '0;
      bit_reg <= '0;
      busy_reg <= 1'b0;
      finish_reg <= 1'b0;
      result_reg <= '0;
    end
    else if (abort)
    begin
      busy_reg <= 1'b0;
      finish_reg <= 1'b0;
      cnt_reg <= '0;
      step_cnt_reg <= '0;
    end
    else if (start)
    begin
      busy_reg <= 1'b1;
      finish_reg <= 1'b0;
      cnt_reg <= '0;
      step_cnt_reg <= '0;
      bit_reg <= {1'b1, {(WIDTH-1){1'b0}}};
      trial_reg <= {1'b1, {(WIDTH-1){1'b0}}};
    end
    else
    begin
      finish_reg <= last_tick;
      cnt_reg <= busy_reg ? cnt_reg + ONE : '0;
      if (last_tick)
      begin
        busy_reg <= 1'b0;
        result_reg <= (bit_reg != '0) ? decided : trial_reg;
      end
      else if (step_tick)
      begin
        step_cnt_reg <= '0;
        if (bit_reg != '0)
        begin
          trial_reg <= decided | (bit_reg >> 1);
          bit_reg <= bit_reg >> 1;
        end
      end
      else if (busy_reg)
      begin
        step_cnt_reg <= step_cnt_reg + ONE;
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/sar_adc_control_unit.sv
// APB register file and control for the 10-bit SAR converter
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_unit #(
  parameter int CH_COUNT = adc_ctrl_pkg::NUM_CHANNELS
) (
  input wire logic pclk, // Bus and hf_osc_clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic comp_in, // Comparator result
  input wire logic standby_req, // Chip in stop, slow or sleep
  output logic [9:0] dac_code, // Ladder DAC setting
  output logic ladder_on, // Ladder connected
  output logic [CH_COUNT-1:0] chan_sel, // One-hot analog input select
  output logic inputs_enable, // Analog inputs gated on
  output logic sample_hold, // Sample-hold tracking
  output logic conv_done_irq // Completion interrupt pulse
);
  logic [7:0] mode_ch_reg;
  logic [7:0] mode_ch_next;
  logic [7:0] timing_reg;
  logic [7:0] timing_next;
  logic [9:0] result_reg;
  logic done_reg;
  logic done_next;
  logic standby_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_word;
  logic pslverr_reg;
  logic irq_reg;
  logic [9:0] dac_reg;
  logic ladder_reg;
  logic [CH_COUNT-1:0] chan_reg;
  logic gate_reg;
  logic sh_reg;

  // Bus phase decode
  wire access = psel && penable;
  wire wr_en = access && pwrite;
  wire rd_en = access && !pwrite;

  // Word index of the byte address against the register indices
  wire [9:0] word_addr = paddr[11:2];
  wire hit_mode = word_addr == {2'b00, adc_ctrl_pkg::IDX_MODE_CH};
  wire hit_time = word_addr == {2'b00, adc_ctrl_pkg::IDX_TIMING};
  wire hit_low = word_addr == {2'b00, adc_ctrl_pkg::IDX_RES_LOW};
  wire hit_high = word_addr == {2'b00, adc_ctrl_pkg::IDX_RES_HIGH};
  wire hit_stby = word_addr == {2'b00, adc_ctrl_pkg::IDX_STANDBY};
  wire mapped = hit_mode | hit_time | hit_low | hit_high | hit_stby;
  wire standby = standby_reg | standby_req;

  // Register fields
  wire [1:0] op_mode_field = mode_ch_reg[adc_ctrl_pkg::MODE_POS +: 2];
  wire conv_start_bit = mode_ch_reg[adc_ctrl_pkg::START_POS];
  wire analog_input_gate = mode_ch_reg[adc_ctrl_pkg::GATE_POS];
  wire [3:0] channel_select = mode_ch_reg[adc_ctrl_pkg::CH_POS +: 4];
  wire ladder_keep_on = timing_reg[adc_ctrl_pkg::KEEP_POS];
  wire [2:0] time_code = timing_reg[adc_ctrl_pkg::TIME_POS +: 3];

  // Mode decode
  wire mode_off = op_mode_field == adc_ctrl_pkg::MODE_OFF;
  wire mode_repeat = op_mode_field == adc_ctrl_pkg::MODE_REPEAT;
  wire mode_valid = op_mode_field == adc_ctrl_pkg::MODE_SINGLE || mode_repeat;

  // Sequencer hookup
  wire seq_busy;
  wire seq_finish;
  wire [9:0] seq_result;
  wire [9:0] seq_dac;
  logic [10:0] conv_cycles;
  // Start when bit set in a usable mode, or on repeat completion
  wire launch = !standby && mode_valid && ((conv_start_bit && !seq_busy)
    || (mode_repeat && seq_finish));
  wire abort = standby || mode_off;
  wire commit = seq_finish && !abort;

  // Conversion time decode; reserved codes fall back to slowest
  always_comb
  begin
    case (time_code)
      3'b000: conv_cycles = adc_ctrl_pkg::CONV_39;
      3'b010: conv_cycles = adc_ctrl_pkg::CONV_78;
      3'b011: conv_cycles = adc_ctrl_pkg::CONV_156;
      3'b100: conv_cycles = adc_ctrl_pkg::CONV_312;
      3'b101: conv_cycles = adc_ctrl_pkg::CONV_624;
      3'b110: conv_cycles = adc_ctrl_pkg::CONV_1248;
      default: conv_cycles = adc_ctrl_pkg::CONV_1248;
    endcase
  end

  sar_sequencer #(
    .WIDTH(adc_ctrl_pkg::RES_BITS)
  ) u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .start(launch),
    .abort(abort),
    .conv_cycles(conv_cycles),
    .comp_in(comp_in),
    .dac_code(seq_dac),
    .busy(seq_busy),
    .finish(seq_finish),
    .result(seq_result)
  );

  // Control register next values; start bit self-clears once launched
  always_comb
  begin
    mode_ch_next = mode_ch_reg;
    timing_next = timing_reg;
    if (wr_en && hit_mode)
      mode_ch_next = pwdata[7:0];
    if (wr_en && hit_time)
      timing_next = {2'b00, pwdata[5:0]};
    if (launch && conv_start_bit)
      mode_ch_next[adc_ctrl_pkg::START_POS] = 1'b0;
    if (standby)
    begin
      mode_ch_next = adc_ctrl_pkg::MODE_CH_RESET;
      timing_next = adc_ctrl_pkg::TIMING_RESET;
    end
  end

  // Done flag: completion set wins over a read clear
  always_comb
  begin
    done_next = done_reg;
    if (rd_en && hit_high)
      done_next = 1'b0;
    if (launch)
      done_next = 1'b0;
    if (commit)
      done_next = 1'b1;
  end

  // Read data mux; flags read-only, undefined bits read as zero
  always_comb
  begin
    rd_word = '0;
    if (hit_mode)
      rd_word[7:0] = mode_ch_reg;
    if (hit_time)
      rd_word[7:0] = {2'b00, timing_reg[5:0]};
    if (hit_low)
      rd_word[7:0] = {result_reg[1:0], done_reg, seq_busy, 4'h0};
    if (hit_high)
      rd_word[7:0] = result_reg[9:2];
    if (hit_stby)
      rd_word[0] = standby_reg;
  end

  // Registers and bus response
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ch_reg <= adc_ctrl_pkg::MODE_CH_RESET;
      timing_reg <= adc_ctrl_pkg::TIMING_RESET;
      result_reg <= {adc_ctrl_pkg::RES_HIGH_RESET, 2'b00};
      done_reg <= 1'b0;
      standby_reg <= 1'b0;
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      mode_ch_reg <= mode_ch_next;
      timing_reg <= timing_next;
      done_reg <= done_next;
      irq_reg <= commit;
      if (commit)
        result_reg <= seq_result;
      else if (standby)
        result_reg <= '0;
      if (wr_en && hit_stby)
        standby_reg <= pwdata[0];
      if (psel && !penable)
      begin
        prdata_reg <= rd_word;
        pslverr_reg <= !mapped;
      end
    end
  end

  // Analog side outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dac_reg <= '0;
      ladder_reg <= 1'b0;
      gate_reg <= 1'b0;
      sh_reg <= 1'b0;
    end
    else
    begin
      dac_reg <= seq_dac;
      ladder_reg <= !standby && (ladder_keep_on || seq_busy);
      gate_reg <= !analog_input_gate;
      sh_reg <= launch;
    end
  end

  // One-hot channel routing; reserved codes select nothing
  genvar ch;
  generate
    for (ch = 0; ch < CH_COUNT; ch++)
    begin : g_ch
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          chan_reg[ch] <= 1'b0;
        else
          chan_reg[ch] <= channel_select == 4'(ch);
      end
    end
  endgenerate

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = pslverr_reg;
  assign dac_code = dac_reg;
  assign ladder_on = ladder_reg;
  assign chan_sel = chan_reg;
  assign inputs_enable = gate_reg;
  assign sample_hold = sh_reg;
  assign conv_done_irq = irq_reg;
endmodule
`default_nettype wire

// file: test/adc_ctrl_assertions.sv
// Port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_checker #(
  parameter int CH_COUNT = 8
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic standby_req, // Standby level
  input wire logic [9:0] dac_code, // Ladder setting
  input wire logic ladder_on, // Ladder connected
  input wire logic [CH_COUNT-1:0] chan_sel, // Input select
  input wire logic inputs_enable, // Inputs on
  input wire logic sample_hold, // Launch pulse
  input wire logic conv_done_irq // Completion pulse
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Pulses last one cycle
  AST_IRQ_PULSE: assert property (conv_done_irq |=> !conv_done_irq)
    else $error("irq wider than one cycle");
  AST_LAUNCH_ONCE: assert property (sample_hold |=> !sample_hold)
    else $error("launch repeated");
  // No completion in the eight cycles after launch
  AST_MIN_TIME: assert property (
    sample_hold |=> !conv_done_irq [*8])
    else $error("conversion ended too soon");
  // Ladder and first trial follow launch
  AST_LADDER_ON: assert property (
    sample_hold |-> ##[1:2] ladder_on)
    else $error("ladder off in conversion");
  AST_MSB_FIRST: assert property (
    sample_hold |-> ##[1:3] dac_code == 10'h200)
    else $error("first trial not the top bit");
  // Standby resets controls; outputs follow two edges later
  AST_STANDBY_INIT: assert property (
    standby_req |-> ##2 !inputs_enable && chan_sel == 8'h01)
    else $error("controls not reset in standby");
  AST_STANDBY_QUIET: assert property (
    standby_req && $past(standby_req) |-> !conv_done_irq && !sample_hold)
    else $error("activity in standby");
  AST_ONE_INPUT: assert property ($onehot0(chan_sel))
    else $error("several inputs selected");
endmodule
bind sar_adc_control_unit adc_checker #(.CH_COUNT(CH_COUNT)) u_chk (
  .pclk(pclk), .presetn(presetn), .standby_req(standby_req),
  .dac_code(dac_code), .ladder_on(ladder_on), .chan_sel(chan_sel),
  .inputs_enable(inputs_enable), .sample_hold(sample_hold),
  .conv_done_irq(conv_done_irq)
);
`default_nettype wire

// file: test/analog_front_model.sv
// Comparator model of the analog side
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
  input wire logic pclk, // Clock
  input wire logic inputs_enable, // Inputs on
  input wire logic [9:0] level, // Held input level
  input wire logic [9:0] dac_code, // Ladder setting
  output logic comp_in // Input above ladder
);
  logic wander = 1'b0;
  // Floating comparator when inputs are gated off
  always @(posedge pclk)
    wander <= ~wander;
  // Half-step offset so the settled code equals level
  assign comp_in = inputs_enable ? ({level, 1'b1} > {dac_code, 1'b0}) : wander;
endmodule
`default_nettype wire

// file: test/sar_adc_control_unit_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_unit_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic standby_req = 1'b0;
  logic [9:0] level = 10'h000;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, comp_in, ladder_on, inputs_enable;
  wire logic sample_hold, conv_done_irq;
  wire logic [9:0] dac_code;
  wire logic [7:0] chan_sel;
  logic last_err;
  int n_mismatch = 0;
  int check_count = 0;
  sar_adc_control_unit u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comp_in(comp_in),
    .standby_req(standby_req), .dac_code(dac_code), .ladder_on(ladder_on),
    .chan_sel(chan_sel), .inputs_enable(inputs_enable),
    .sample_hold(sample_hold), .conv_done_irq(conv_done_irq)
  );
  analog_front_model u_front (
    .pclk(pclk), .inputs_enable(inputs_enable), .level(level),
    .dac_code(dac_code), .comp_in(comp_in)
  );
  // 100 MHz clock
  always #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer, then an idle cycle
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge pclk);
    end
    if (n >= 50)
    begin
      n_mismatch++;
      $display("wrong value at %0t: no ready from slave", $time);
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    while (conv_done_irq !== 1'b1 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic t_reset;
    rd(12'h038, 32'h10);
    rd(12'h084, 32'h00);
    rd(12'h080, 32'h00);
    rd(12'h03c, 32'h10);
    chk(inputs_enable, 1'b0);
    chk(chan_sel, 8'h01);
    chk(pready, 1'b1);
    rd(12'h040, 32'h00);
    chk(last_err, 1'b1);
  endtask
  // Every defined time code and reserved code 7, on successive channels
  task automatic t_single;
    int cyc[7] = '{39, 78, 156, 312, 624, 1248, 1248};
    int tc[7] = '{0, 2, 3, 4, 5, 6, 7};
    int n;
    int ch;
    for (int c = 0; c < 7; c++)
    begin
      ch = (c + 2) % 8;
      level <= 10'h3a5 - 10'(c * 77);
      wr(12'h03c, 8'h10 | 8'(tc[c] << 1));
      wr(12'h038, 8'ha0 | 8'(ch));
      wait_irq(n);
      chk(n >= cyc[c] - 1 && n <= cyc[c] + 3, 1'b1);
      chk(chan_sel, 32'h1 << ch);
      chk(inputs_enable, 1'b1);
      rd(12'h038, 32'h20 | ch);
      rd(12'h080, {24'h0, level[1:0], 6'h20});
      rd(12'h084, {24'h0, level[9:2]});
      rd(12'h080, {24'h0, level[1:0], 6'h00});
    end
  endtask
  // Repeat keeps done set across restarts; off aborts and keeps result
  task automatic t_repeat;
    int n;
    level <= 10'h155;
    wr(12'h03c, 8'h10);
    wr(12'h038, 8'he1);
    rd(12'h080, 32'hd0);
    wait_irq(n);
    @(posedge pclk);
    wait_irq(n);
    chk(n >= 38 && n <= 42, 1'b1);
    wr(12'h038, 8'h01);
    rd(12'h080, 32'h60);
    rd(12'h084, 32'h55);
    wait_irq(n);
    chk(n, 2000);
    wr(12'h038, 8'hc1);
    rd(12'h080, 32'h40);
    wr(12'h038, 8'h81);
    rd(12'h080, 32'h40);
  endtask
  task automatic t_standby;
    wr(12'h03c, 8'hf0);
    rd(12'h03c, 32'h30);
    chk(ladder_on, 1'b1);
    wr(12'h038, 8'ha1);
    rd(12'h080, 32'h50);
    standby_req <= 1'b1;
    @(posedge pclk);
    wr(12'h038, 8'h67);
    rd(12'h038, 32'h10);
    rd(12'h03c, 32'h10);
    chk(ladder_on, 1'b0);
    rd(12'h080, 32'h00);
    rd(12'h084, 32'h00);
    standby_req <= 1'b0;
    @(posedge pclk);
    wr(12'h038, 8'h07);
    rd(12'h038, 32'h07);
    wr(12'h084, 8'hff);
    rd(12'h084, 32'h00);
    wr(12'h038, 8'h18);
    @(posedge pclk);
    chk(chan_sel, 8'h00);
    chk(inputs_enable, 1'b0);
    wr(12'h0c0, 8'h01);
    rd(12'h0c0, 32'h01);
    rd(12'h038, 32'h10);
    wr(12'h0c0, 8'h00);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_single;
    t_repeat;
    t_standby;
    conclude;
  end
  // Hang guard
  initial
  begin
    #300000;
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    conclude;
  end
endmodule
`default_nettype wire
